// ### hdl/dcfm_top.sv
// two queues with synchronised flags, two mailboxes, threshold programming
// Notes on behaviour
// - port a empty, port b full use b-to-a thresholds
// - word moved to output register frees its slot
// - input ready rises second writer edge after read
// - read in same reference cycle misses first edge
// - almost empty follows reader clock, own queue threshold
// - almost empty low at threshold or fewer
// - output register word counts as already read
// - almost empty rises second reader edge after write
// - write in same reference cycle misses first edge
// - almost full follows writer clock, own queue threshold
// - almost full low from depth minus threshold
// - almost full rises second writer edge after read
// - read in same reference cycle misses first edge
// - one 36-bit mailbox per direction, select chooses
// - mailbox write loads on writer port edge
// - mailbox write drops full flag, blocks rewrites
// - data out from queue or mailbox by select
// - mailbox read on far port raises flag
// - mailbox read leaves contents unchanged
// - fall-through on third reader edge after write
// - input ready and almost flags pass two stages into their port, output ready three; mailbox flags are not synchronised
// - writes ignored while input ready low
// - port b write needs full select condition
// - reads ignored while output ready low, data held
`timescale 1ns/1ns

module dcfm_queue
  import dcfm_pkg::*;
#(
  parameter int WIDTH = DATA_WIDTH,
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_wr_tick,
  input wire logic i_rd_tick,
  input wire logic i_wr_req,
  input wire logic i_rd_req,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic [AW-1:0] i_empty_threshold,
  input wire logic [AW-1:0] i_full_threshold,
  output logic o_input_ready,
  output logic o_output_ready,
  output logic o_almost_empty_n,
  output logic o_almost_full_n,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_PW = PW'(DEPTH);
  localparam logic [PW-1:0] ONE_PW = PW'(1);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [PW-1:0] rptr_seen_r, rptr_seen_nxt;
  logic [PW-1:0] wptr_seen_r, wptr_seen_nxt, wptr_seen2_r, wptr_seen2_nxt;
  logic ir_r, ir_nxt, or_r, or_nxt, ae_n_r, ae_n_nxt, af_n_r, af_n_nxt;
  logic [WIDTH-1:0] dout_r, dout_nxt;
  logic wr_hit, ld_hit;
  logic [PW-1:0] full_level;

  function automatic logic [PW-1:0] fill(input logic [PW-1:0] wp, input logic [PW-1:0] rp);
    return wp - rp;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    wptr_nxt = wptr_r;
    rptr_nxt = rptr_r;
    rptr_seen_nxt = rptr_seen_r;
    wptr_seen_nxt = wptr_seen_r;
    wptr_seen2_nxt = wptr_seen2_r;
    ir_nxt = ir_r;
    or_nxt = or_r;
    ae_n_nxt = ae_n_r;
    af_n_nxt = af_n_r;
    dout_nxt = dout_r;
    full_level = DEPTH_PW - {1'b0, i_full_threshold};
    wr_hit = i_wr_tick & i_wr_req & ir_r;
    ld_hit = i_rd_tick & (wptr_seen2_r != rptr_r) & (~or_r | i_rd_req);
    if (wr_hit) begin
      wptr_nxt = wptr_r + ONE_PW;
    end
    // writer side sees the read pointer one edge late, flag on the next
    if (i_wr_tick) begin
      rptr_seen_nxt = rptr_r;
      ir_nxt = fill(wptr_nxt, rptr_seen_r) != DEPTH_PW;
      af_n_nxt = fill(wptr_nxt, rptr_seen_r) < full_level;
    end
    // reader side: two stages for almost empty, three for fall-through
    if (i_rd_tick) begin
      wptr_seen_nxt = wptr_r;
      wptr_seen2_nxt = wptr_seen_r;
      if (ld_hit) begin
        dout_nxt = mem[rptr_r[AW-1:0]];
        rptr_nxt = rptr_r + ONE_PW;
        or_nxt = 1'b1;
      end else if (or_r & i_rd_req) begin
        or_nxt = 1'b0;
      end
      ae_n_nxt = fill(wptr_seen_r, rptr_nxt) > {1'b0, i_empty_threshold};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      rptr_seen_r <= '0;
      wptr_seen_r <= '0;
      wptr_seen2_r <= '0;
      ir_r <= INPUT_READY_RST;
      or_r <= OUTPUT_READY_RST;
      ae_n_r <= ALMOST_EMPTY_N_RST;
      af_n_r <= ALMOST_FULL_N_RST;
      dout_r <= '0;
    end else begin
      wptr_r <= wptr_nxt;
      rptr_r <= rptr_nxt;
      rptr_seen_r <= rptr_seen_nxt;
      wptr_seen_r <= wptr_seen_nxt;
      wptr_seen2_r <= wptr_seen2_nxt;
      ir_r <= ir_nxt;
      or_r <= or_nxt;
      ae_n_r <= ae_n_nxt;
      af_n_r <= af_n_nxt;
      dout_r <= dout_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (wr_hit) begin
      mem[wptr_r[AW-1:0]] <= i_wr_data;
    end
  end

  assign o_input_ready = ir_r;
  assign o_output_ready = or_r;
  assign o_almost_empty_n = ae_n_r;
  assign o_almost_full_n = af_n_r;
  assign o_rd_data = dout_r;
endmodule

module dcfm_top
  import dcfm_pkg::*;
#(
  parameter int WIDTH = DATA_WIDTH,
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_program_offsets,
  input wire logic i_port_a_clock,
  input wire logic i_port_a_chip_select_n,
  input wire logic i_port_a_write_read_select,
  input wire logic i_port_a_enable,
  input wire logic i_port_a_mailbox_select,
  input wire logic [WIDTH-1:0] i_port_a_data,
  output logic [WIDTH-1:0] o_port_a_data,
  output logic o_port_a_data_oe,
  output logic o_port_a_input_ready,
  output logic o_port_a_output_ready,
  output logic o_port_a_almost_empty_n,
  output logic o_port_a_almost_full_n,
  output logic o_a_to_b_mailbox_full_n,
  input wire logic i_port_b_clock,
  input wire logic i_port_b_chip_select_n,
  input wire logic i_port_b_write_read_select,
  input wire logic i_port_b_enable,
  input wire logic i_port_b_mailbox_select,
  input wire logic [WIDTH-1:0] i_port_b_data,
  output logic [WIDTH-1:0] o_port_b_data,
  output logic o_port_b_data_oe,
  output logic o_port_b_input_ready,
  output logic o_port_b_output_ready,
  output logic o_port_b_almost_empty_n,
  output logic o_port_b_almost_full_n,
  output logic o_b_to_a_mailbox_full_n
);
  // ----------------------------------------------------------------
  // port decode
  // ----------------------------------------------------------------
  logic a_wr, a_rd, b_wr, b_rd, prog_done;
  logic [WIDTH-1:0] ab_dout, ba_dout;
  assign a_wr = ~i_port_a_chip_select_n & i_port_a_enable & i_port_a_write_read_select;
  assign a_rd = ~i_port_a_chip_select_n & i_port_a_enable & ~i_port_a_write_read_select;
  assign b_wr = ~i_port_b_chip_select_n & i_port_b_enable & ~i_port_b_write_read_select;
  assign b_rd = ~i_port_b_chip_select_n & i_port_b_enable & i_port_b_write_read_select;

  // ----------------------------------------------------------------
  // thresholds and their programming
  // ----------------------------------------------------------------
  dcfm_prog_t prog_r, prog_nxt;
  logic [AW-1:0] ab_empty_r, ab_empty_nxt, ba_empty_r, ba_empty_nxt;
  logic [AW-1:0] ab_full_r, ab_full_nxt, ba_full_r, ba_full_nxt;
  logic prog_wr;

  assign prog_done = (prog_r == DCFM_PROG_DONE);

  always_comb begin
    prog_nxt = prog_r;
    ab_empty_nxt = ab_empty_r;
    ba_empty_nxt = ba_empty_r;
    ab_full_nxt = ab_full_r;
    ba_full_nxt = ba_full_r;
    prog_wr = i_port_a_clock & a_wr & ~i_port_a_mailbox_select;
    if (!prog_done && !i_program_offsets) begin
      prog_nxt = DCFM_PROG_DONE;
    end else if (prog_wr) begin
      case (prog_r)
        DCFM_PROG_AB_EMPTY: begin
          ab_empty_nxt = i_port_a_data[AW-1:0];
          prog_nxt = DCFM_PROG_BA_EMPTY;
        end
        DCFM_PROG_BA_EMPTY: begin
          ba_empty_nxt = i_port_a_data[AW-1:0];
          prog_nxt = DCFM_PROG_AB_FULL;
        end
        DCFM_PROG_AB_FULL: begin
          ab_full_nxt = i_port_a_data[AW-1:0];
          prog_nxt = DCFM_PROG_BA_FULL;
        end
        DCFM_PROG_BA_FULL: begin
          ba_full_nxt = i_port_a_data[AW-1:0];
          prog_nxt = DCFM_PROG_DONE;
        end
        DCFM_PROG_DONE: begin
          prog_nxt = DCFM_PROG_DONE;
        end
        default: begin
          prog_nxt = DCFM_PROG_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      prog_r <= DCFM_PROG_AB_EMPTY;
      ab_empty_r <= AW'(A_TO_B_EMPTY_THRESHOLD_RST);
      ba_empty_r <= AW'(B_TO_A_EMPTY_THRESHOLD_RST);
      ab_full_r <= AW'(A_TO_B_FULL_THRESHOLD_RST);
      ba_full_r <= AW'(B_TO_A_FULL_THRESHOLD_RST);
    end else begin
      prog_r <= prog_nxt;
      ab_empty_r <= ab_empty_nxt;
      ba_empty_r <= ba_empty_nxt;
      ab_full_r <= ab_full_nxt;
      ba_full_r <= ba_full_nxt;
    end
  end

  // ----------------------------------------------------------------
  // queues
  // ----------------------------------------------------------------
  dcfm_queue #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_a_to_b_queue (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_wr_tick(i_port_a_clock),
    .i_rd_tick(i_port_b_clock),
    .i_wr_req(a_wr & ~i_port_a_mailbox_select & prog_done),
    .i_rd_req(b_rd & ~i_port_b_mailbox_select),
    .i_wr_data(i_port_a_data),
    .i_empty_threshold(ab_empty_r),
    .i_full_threshold(ab_full_r),
    .o_input_ready(o_port_a_input_ready),
    .o_output_ready(o_port_b_output_ready),
    .o_almost_empty_n(o_port_b_almost_empty_n),
    .o_almost_full_n(o_port_a_almost_full_n),
    .o_rd_data(ab_dout)
  );

  dcfm_queue #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_b_to_a_queue (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_wr_tick(i_port_b_clock),
    .i_rd_tick(i_port_a_clock),
    .i_wr_req(b_wr & ~i_port_b_mailbox_select & prog_done),
    .i_rd_req(a_rd & ~i_port_a_mailbox_select),
    .i_wr_data(i_port_b_data),
    .i_empty_threshold(ba_empty_r),
    .i_full_threshold(ba_full_r),
    .o_input_ready(o_port_b_input_ready),
    .o_output_ready(o_port_a_output_ready),
    .o_almost_empty_n(o_port_a_almost_empty_n),
    .o_almost_full_n(o_port_b_almost_full_n),
    .o_rd_data(ba_dout)
  );

  // ----------------------------------------------------------------
  // mailboxes and data outputs
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mb_ab_r, mb_ab_nxt, mb_ba_r, mb_ba_nxt;
  logic mb_ab_full_n_r, mb_ab_full_n_nxt, mb_ba_full_n_r, mb_ba_full_n_nxt;
  logic [WIDTH-1:0] a_out_r, a_out_nxt, b_out_r, b_out_nxt;
  logic a_oe_r, a_oe_nxt, b_oe_r, b_oe_nxt;

  always_comb begin
    mb_ab_nxt = mb_ab_r;
    mb_ba_nxt = mb_ba_r;
    mb_ab_full_n_nxt = mb_ab_full_n_r;
    mb_ba_full_n_nxt = mb_ba_full_n_r;
    // a far-side read and a write in one cycle: the write wins
    if (i_port_b_clock & b_rd & i_port_b_mailbox_select) begin
      mb_ab_full_n_nxt = 1'b1;
    end
    if (i_port_a_clock & a_rd & i_port_a_mailbox_select) begin
      mb_ba_full_n_nxt = 1'b1;
    end
    if (i_port_a_clock & a_wr & i_port_a_mailbox_select & mb_ab_full_n_r) begin
      mb_ab_nxt = i_port_a_data;
      mb_ab_full_n_nxt = 1'b0;
    end
    if (i_port_b_clock & b_wr & i_port_b_mailbox_select & mb_ba_full_n_r) begin
      mb_ba_nxt = i_port_b_data;
      mb_ba_full_n_nxt = 1'b0;
    end
    a_out_nxt = i_port_a_mailbox_select ? mb_ba_r : ba_dout;
    b_out_nxt = i_port_b_mailbox_select ? mb_ab_r : ab_dout;
    a_oe_nxt = ~i_port_a_chip_select_n & ~i_port_a_write_read_select;
    b_oe_nxt = ~i_port_b_chip_select_n & i_port_b_write_read_select;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      mb_ab_r <= '0;
      mb_ba_r <= '0;
      mb_ab_full_n_r <= MAILBOX_FULL_N_RST;
      mb_ba_full_n_r <= MAILBOX_FULL_N_RST;
      a_out_r <= '0;
      b_out_r <= '0;
      a_oe_r <= 1'b0;
      b_oe_r <= 1'b0;
    end else begin
      mb_ab_r <= mb_ab_nxt;
      mb_ba_r <= mb_ba_nxt;
      mb_ab_full_n_r <= mb_ab_full_n_nxt;
      mb_ba_full_n_r <= mb_ba_full_n_nxt;
      a_out_r <= a_out_nxt;
      b_out_r <= b_out_nxt;
      a_oe_r <= a_oe_nxt;
      b_oe_r <= b_oe_nxt;
    end
  end

  assign o_port_a_data = a_out_r;
  assign o_port_b_data = b_out_r;
  assign o_port_a_data_oe = a_oe_r;
  assign o_port_b_data_oe = b_oe_r;
  assign o_a_to_b_mailbox_full_n = mb_ab_full_n_r;
  assign o_b_to_a_mailbox_full_n = mb_ba_full_n_r;
endmodule

// ### shared/dcfm_pkg.sv
// shared constants for the dual-port queue flag and mailbox block
package dcfm_pkg;

  // ----------------------------------------------------------------
  // data path and depth
  // ----------------------------------------------------------------
  localparam int DATA_WIDTH = 36;
  localparam int QUEUE_DEPTH = 256;

  // ----------------------------------------------------------------
  // threshold reset values (loaded while reset is held)
  // ----------------------------------------------------------------
  localparam int A_TO_B_EMPTY_THRESHOLD_RST = 8;
  localparam int B_TO_A_EMPTY_THRESHOLD_RST = 8;
  localparam int A_TO_B_FULL_THRESHOLD_RST = 8;
  localparam int B_TO_A_FULL_THRESHOLD_RST = 8;

  // ----------------------------------------------------------------
  // flag reset values
  // ----------------------------------------------------------------
  localparam logic INPUT_READY_RST = 1'b1;
  localparam logic OUTPUT_READY_RST = 1'b0;
  localparam logic ALMOST_EMPTY_N_RST = 1'b0;
  localparam logic ALMOST_FULL_N_RST = 1'b1;
  localparam logic MAILBOX_FULL_N_RST = 1'b1;

  // ----------------------------------------------------------------
  // threshold programming sequence over port a
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DCFM_PROG_AB_EMPTY = 5'b0_0001,
    DCFM_PROG_BA_EMPTY = 5'b0_0010,
    DCFM_PROG_AB_FULL  = 5'b0_0100,
    DCFM_PROG_BA_FULL  = 5'b0_1000,
    DCFM_PROG_DONE     = 5'b1_0000
  } dcfm_prog_t;

endpackage

// ### sim/dcfm_chk.sv
// port-level assertion checker for the queue flag and mailbox block
`timescale 1ns/1ns
module dcfm_chk
  import dcfm_pkg::*;
#(
  parameter int WIDTH = DATA_WIDTH
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_port_a_clock,
  input wire logic i_port_a_chip_select_n,
  input wire logic i_port_a_write_read_select,
  input wire logic i_port_a_enable,
  input wire logic i_port_a_mailbox_select,
  input wire logic [WIDTH-1:0] i_port_a_data,
  input wire logic o_port_a_data_oe,
  input wire logic o_a_to_b_mailbox_full_n,
  input wire logic i_port_b_clock,
  input wire logic i_port_b_chip_select_n,
  input wire logic i_port_b_write_read_select,
  input wire logic i_port_b_enable,
  input wire logic i_port_b_mailbox_select,
  input wire logic [WIDTH-1:0] o_port_b_data,
  input wire logic o_port_b_input_ready,
  input wire logic o_port_b_output_ready,
  input wire logic o_port_b_almost_empty_n,
  input wire logic o_port_b_almost_full_n,
  input wire logic o_b_to_a_mailbox_full_n
);
  // ------
  // mailbox traffic
  // ------
  logic a_go, b_go, ab_wr, ab_rd, ba_wr, ba_rd;
  logic [WIDTH-1:0] ab_r;
  assign a_go = i_port_a_clock & ~i_port_a_chip_select_n & i_port_a_enable & i_port_a_mailbox_select;
  assign b_go = i_port_b_clock & ~i_port_b_chip_select_n & i_port_b_enable & i_port_b_mailbox_select;
  assign ab_wr = a_go & i_port_a_write_read_select & o_a_to_b_mailbox_full_n;
  assign ab_rd = b_go & i_port_b_write_read_select;
  assign ba_wr = b_go & ~i_port_b_write_read_select & o_b_to_a_mailbox_full_n;
  assign ba_rd = a_go & ~i_port_a_write_read_select;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ab_r <= '0;
    end else if (ab_wr) begin
      ab_r <= i_port_a_data;
    end
  end
  // ------
  // assertions
  // ------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  a_ab_mbox_load: assert property (ab_wr |=> !o_a_to_b_mailbox_full_n)
    else $error("a to b mailbox flag high after write");
  a_ab_mbox_free: assert property (ab_rd && !ab_wr |=> o_a_to_b_mailbox_full_n)
    else $error("a to b mailbox flag low after read");
  a_ab_mbox_hold: assert property (!o_a_to_b_mailbox_full_n && !ab_rd |=> !o_a_to_b_mailbox_full_n)
    else $error("a to b mailbox flag rose without read");
  a_ba_mbox_load: assert property (ba_wr |=> !o_b_to_a_mailbox_full_n)
    else $error("b to a mailbox flag high after write");
  a_ba_mbox_free: assert property (ba_rd && !ba_wr |=> o_b_to_a_mailbox_full_n)
    else $error("b to a mailbox flag low after read");
  a_b_mbox_data: assert property (
    !$past(i_srst) && $past(!i_port_b_chip_select_n && i_port_b_write_read_select && i_port_b_mailbox_select)
    |-> o_port_b_data == $past(ab_r)) else $error("port b mailbox data wrong");
  a_a_oe_sel: assert property (
    !$past(i_srst) |-> o_port_a_data_oe == $past(!i_port_a_chip_select_n && !i_port_a_write_read_select))
    else $error("port a output enable wrong");
  a_b_flag_sync: assert property (
    !$past(i_port_b_clock) && !$past(i_srst) |-> $stable({o_port_b_input_ready, o_port_b_output_ready,
    o_port_b_almost_empty_n, o_port_b_almost_full_n})) else $error("port b flag moved off its clock");
endmodule

bind dcfm_top dcfm_chk #(.WIDTH(WIDTH)) i_dcfm_chk (.*);

// ### sim/dcfm_master.sv
// bus master model for one port: free-running port clock and data lines
`timescale 1ns/1ns
module dcfm_master
  import dcfm_pkg::*;
#(
  parameter int PERIOD = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_drive,
  input wire logic [DATA_WIDTH-1:0] i_word,
  output logic o_tick,
  output logic [DATA_WIDTH-1:0] o_data
);
  int cnt = 0;
  logic tick_r = 1'h0;
  logic [DATA_WIDTH-1:0] last_r = '0;
  always_ff @(posedge i_ref_clk) begin
    cnt <= (cnt + 1) % PERIOD;
    tick_r <= (cnt == 0);
    if (i_drive) begin
      last_r <= i_word;
    end
  end
  assign o_tick = tick_r;
  // released lines show the inverse of the last word
  assign o_data = i_drive ? i_word : ~last_r;
endmodule

// ### sim/testbench.sv
// self-checking bench for the queue flag and mailbox block
`timescale 1ns/1ns
module testbench
  import dcfm_pkg::*;
;
  localparam logic [3:0] RF = {ALMOST_FULL_N_RST, INPUT_READY_RST, ALMOST_EMPTY_N_RST, OUTPUT_READY_RST};
  localparam int AF = QUEUE_DEPTH - B_TO_A_FULL_THRESHOLD_RST;
  logic i_ref_clk = 1'h0, i_srst = 1'h1, i_program_offsets = 1'h0;
  logic i_port_a_chip_select_n = 1'h1, i_port_a_write_read_select = 1'h0, i_port_a_enable = 1'h0;
  logic i_port_b_chip_select_n = 1'h1, i_port_b_write_read_select = 1'h1, i_port_b_enable = 1'h0;
  logic i_port_a_mailbox_select = 1'h0, i_port_b_mailbox_select = 1'h0, i_port_a_clock, i_port_b_clock;
  logic o_port_a_data_oe, o_port_a_input_ready, o_port_a_output_ready, o_port_a_almost_empty_n;
  logic o_port_a_almost_full_n, o_a_to_b_mailbox_full_n, o_port_b_data_oe, o_port_b_input_ready;
  logic o_port_b_output_ready, o_port_b_almost_empty_n, o_port_b_almost_full_n, o_b_to_a_mailbox_full_n;
  logic [DATA_WIDTH-1:0] i_port_a_data, i_port_b_data, o_port_a_data, o_port_b_data, word_a = '0, word_b = '0;
  logic [3:0] aflags, bflags;
  int checks = 0, bad_count = 0, n;
  assign aflags = {o_port_a_almost_full_n, o_port_a_input_ready, o_port_a_almost_empty_n, o_port_a_output_ready};
  assign bflags = {o_port_b_almost_full_n, o_port_b_input_ready, o_port_b_almost_empty_n, o_port_b_output_ready};
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
  always #2 i_ref_clk = ~i_ref_clk;
  dcfm_top i_dcfm_top (.*);
  dcfm_master #(.PERIOD(1)) i_dcfm_master_a (.i_ref_clk(i_ref_clk), .i_word(word_a), .o_tick(i_port_a_clock),
    .i_drive(i_port_a_enable & i_port_a_write_read_select), .o_data(i_port_a_data));
  dcfm_master #(.PERIOD(3)) i_dcfm_master_b (.i_ref_clk(i_ref_clk), .i_word(word_b), .o_tick(i_port_b_clock),
    .i_drive(i_port_b_enable & ~i_port_b_write_read_select), .o_data(i_port_b_data));
  // ------
  // port cycles
  // ------
  task automatic a_op(input logic wr, input logic mb, input logic [DATA_WIDTH-1:0] d);
    @(posedge i_ref_clk);
    i_port_a_chip_select_n <= 1'h0;
    i_port_a_enable <= 1'h1;
    i_port_a_write_read_select <= wr;
    i_port_a_mailbox_select <= mb;
    word_a <= d;
    do @(posedge i_ref_clk); while (!i_port_a_clock);
    i_port_a_enable <= 1'h0;
    #1;
  endtask
  task automatic b_op(input logic wr, input logic mb, input logic [DATA_WIDTH-1:0] d);
    @(posedge i_ref_clk);
    i_port_b_chip_select_n <= 1'h0;
    i_port_b_enable <= 1'h1;
    i_port_b_write_read_select <= wr;
    i_port_b_mailbox_select <= mb;
    word_b <= d;
    do @(posedge i_ref_clk); while (!i_port_b_clock);
    i_port_b_enable <= 1'h0;
    #1;
  endtask
  task automatic b_edges(input int sel, output int cnt);
    cnt = 0;
    for (int k = 0; k < 60 && bflags[sel] !== 1'h1; k++) begin
      @(posedge i_ref_clk);
      cnt += i_port_b_clock;
      #1;
    end
  endtask
  // ------
  // scenarios
  // ------
  task automatic test_mailbox;
    a_op(1'h1, 1'h1, 36'h1_2345_6789);
    `CHK("ab flag", 1'h0, o_a_to_b_mailbox_full_n)
    a_op(1'h1, 1'h1, 36'h0_0000_00ff);
    b_op(1'h1, 1'h1, '0);
    `CHK("ab mail", 36'h1_2345_6789, o_port_b_data)
    `CHK("ab freed", 1'h1, o_a_to_b_mailbox_full_n)
    b_op(1'h1, 1'h1, '0);
    `CHK("ab reread", 36'h1_2345_6789, o_port_b_data)
    b_op(1'h0, 1'h1, 36'h0_dead_beef);
    `CHK("ba flag", 1'h0, o_b_to_a_mailbox_full_n)
    a_op(1'h0, 1'h1, '0);
    `CHK("ba mail", 36'h0_dead_beef, o_port_a_data)
    `CHK("ba freed", 1'h1, o_b_to_a_mailbox_full_n)
    $display("mailbox test done");
  endtask
  task automatic test_fall;
    b_op(1'h1, 1'h0, '0);
    a_op(1'h1, 1'h0, 36'h0_abcd_0001);
    b_edges(0, n);
    `CHK("fall edges", 3, n)
    b_op(1'h1, 1'h0, '0);
    `CHK("first word", 36'h0_abcd_0001, o_port_b_data)
    `CHK("empty ready", 1'h0, o_port_b_output_ready)
    `CHK("one word ae", 1'h0, o_port_b_almost_empty_n)
    b_op(1'h1, 1'h0, '0);
    `CHK("held word", 36'h0_abcd_0001, o_port_b_data)
    $display("fall through test done");
  endtask
  task automatic test_aempty;
    for (int i = 0; i <= A_TO_B_EMPTY_THRESHOLD_RST; i++) begin
      a_op(1'h1, 1'h0, DATA_WIDTH'(i));
    end
    repeat (12) @(posedge i_ref_clk);
    #1;
    `CHK("ae at level", 1'h0, o_port_b_almost_empty_n)
    a_op(1'h1, 1'h0, '0);
    b_edges(1, n);
    `CHK("ae edges", 2, n)
    $display("almost empty test done");
  endtask
  task automatic test_afull;
    a_op(1'h0, 1'h0, '0);
    for (int i = 1; i <= QUEUE_DEPTH + 1; i++) begin
      b_op(1'h0, 1'h0, DATA_WIDTH'(i));
      if (i == AF) `CHK("af below", 1'h1, o_port_b_almost_full_n)
      if (i == AF + 1) `CHK("af at level", 1'h0, o_port_b_almost_full_n)
    end
    `CHK("full ir", 1'h0, o_port_b_input_ready)
    b_op(1'h0, 1'h0, 36'h0_0bad_0bad);
    `CHK("still full", 1'h0, o_port_b_input_ready)
    a_op(1'h0, 1'h0, '0);
    `CHK("b word one", 36'h0_0000_0001, o_port_a_data)
    b_edges(2, n);
    `CHK("ir edges", 2, n)
    for (int i = 0; i < 8; i++) begin
      a_op(1'h0, 1'h0, '0);
    end
    b_edges(3, n);
    `CHK("af edges", 2, n)
    `CHK("b word ten", 36'h0_0000_000a, o_port_a_data)
    $display("almost full test done");
  endtask
  task automatic test_program;
    @(posedge i_ref_clk);
    i_srst <= 1'h1;
    i_program_offsets <= 1'h1;
    repeat (4) @(posedge i_ref_clk);
    i_srst <= 1'h0;
    a_op(1'h1, 1'h0, 36'h0_0000_0004);
    a_op(1'h1, 1'h0, 36'h0_0000_0002);
    a_op(1'h1, 1'h0, 36'h0_0000_0003);
    a_op(1'h1, 1'h0, 36'h0_0000_0005);
    @(posedge i_ref_clk);
    i_program_offsets <= 1'h0;
    #1;
    `CHK("prog reset", 2'h1, {o_port_a_output_ready, o_port_b_input_ready})
    for (int i = 1; i <= 3; i++) begin
      b_op(1'h0, 1'h0, DATA_WIDTH'(i));
    end
    repeat (12) @(posedge i_ref_clk);
    #1;
    `CHK("prog ae low", 1'h0, o_port_a_almost_empty_n)
    b_op(1'h0, 1'h0, 36'h0_0000_0004);
    repeat (6) @(posedge i_ref_clk);
    #1;
    `CHK("prog ae high", 1'h1, o_port_a_almost_empty_n)
    $display("program test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (19) @(posedge i_ref_clk);
    #1;
    `CHK("reset flags", {RF, RF}, {aflags, bflags})
    `CHK("reset mail", 2'h3, {o_a_to_b_mailbox_full_n, o_b_to_a_mailbox_full_n})
    @(posedge i_ref_clk);
    i_srst <= 1'h0;
    test_mailbox;
    test_fall;
    test_aempty;
    test_afull;
    test_program;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    end_of_test;
  end
endmodule
